//--- inc/paec_pkg.sv
// Shared constants and types for the PMBus alert and enable control block
package paec_pkg;
	// ********************************
	// Bus addresses and command codes
	// ********************************
	localparam logic [6:0] PAEC_ADDR_MST = 7'h24;
	localparam logic [6:0] PAEC_ADDR_SLV = 7'h25;
	localparam logic [6:0] PAEC_ADDR_ARA = 7'h0c;
	localparam logic [7:0] PAEC_CMD_OPER = 8'h01;
	localparam logic [7:0] PAEC_CMD_CLR = 8'h03;
	localparam logic [7:0] PAEC_CMD_STORE = 8'h11;
	localparam logic [7:0] PAEC_CMD_MASK = 8'h1b;
	localparam logic [7:0] PAEC_CRC_POLY = 8'h07;
	localparam int PAEC_OPER_ON = 7;
	localparam logic [2:0] PAEC_LEN_1 = 3'h1;
	localparam logic [2:0] PAEC_LEN_2 = 3'h2;

	// ********************************
	// Register map and fields
	// ********************************
	localparam logic [7:0] PAEC_OFF_OPT = 8'h00;
	localparam logic [7:0] PAEC_OFF_INT_ST = 8'h04;
	localparam logic [7:0] PAEC_OFF_INT_EN = 8'h08;
	localparam logic [7:0] PAEC_OFF_INT_CLR = 8'h0c;
	localparam logic [7:0] PAEC_OFF_STATE = 8'h10;
	localparam logic [15:0] PAEC_OPT_RST = 16'h8008;
	localparam int PAEC_OPT_MODE = 0;
	localparam int PAEC_OPT_POL = 2;
	localparam int PAEC_OPT_AUTO = 3;
	localparam int PAEC_OPT_RESP = 4;
	localparam int PAEC_OPT_LSLV = 6;
	localparam int PAEC_OPT_DUTY = 8;
	localparam int PAEC_EV_UV = 0;
	localparam int PAEC_EV_TON = 1;
	localparam int PAEC_EV_PEC = 2;
	localparam int PAEC_EV_ARA = 3;
	localparam int PAEC_EV_STORE = 4;
	localparam int PAEC_EV_CLR = 5;
	localparam int PAEC_EV_N = 6;
	localparam int PAEC_PM_N = 3;

	// ********************************
	// Timing
	// ********************************
	localparam int PAEC_CLK_MHZ = 200;
	localparam logic [7:0] PAEC_SS_CYCLES = 8'h80;
	localparam int PAEC_RESTART_RISES = 7;

	typedef enum logic [1:0] {PAEC_EN_PIN, PAEC_EN_CMD, PAEC_EN_BOTH} paec_en_mode_t;
	typedef enum logic [1:0] {PAEC_RESP_LATCH, PAEC_RESP_RESTART, PAEC_RESP_IGNORE} paec_resp_t;
	typedef struct packed {
		logic vld;
		logic [2:0] idx;
		logic [7:0] data;
	} paec_rx_t;
	typedef struct packed {
		logic hs;
		logic ls;
	} paec_gate_t;

	// Glitch filter: level moves only when the 2nd and 3rd stages agree
	function automatic logic paec_filt(input logic [2:0] s, input logic f);
		return (s[1] == s[2]) ? s[2] : f;
	endfunction
endpackage

//--- core/paec_i2c.sv
// Oversampled SMBus slave: address match, byte receive, alert reply, CRC-8
`timescale 1ns/1ps
module paec_i2c (
	input wire logic hclk, // System clock
	input wire logic hresetn, // Async reset, active low
	input wire logic scl_i, // Bus clock pin level
	input wire logic sda_i, // Bus data pin level
	output logic sda_o, // Data pin drive value
	output logic sda_oe, // Data pin pull-low enable
	input wire logic [6:0] own_addr, // Our 7-bit address
	input wire logic alert, // We are pulling the alert line
	output paec_pkg::paec_rx_t rx, // Received byte after address
	output logic done, // Stop ends our write
	output logic [2:0] nbytes, // Bytes after address
	output logic crc_ok, // Running check is zero
	output logic ara_done // Alert reply sent
);
	import paec_pkg::*;
	typedef enum logic [2:0] {I_IDLE, I_ADDR, I_ACK, I_RX, I_TX, I_TXA} paec_i2c_fsm_t;
	typedef struct packed {
		logic [2:0] scl_s;
		logic [2:0] sda_s;
		logic scl_f;
		logic sda_f;
		paec_i2c_fsm_t st;
		logic [2:0] bitc;
		logic [7:0] sh;
		logic [7:0] crc;
		logic ack;
		logic ph;
		logic rd;
		logic mine;
		logic [2:0] cnt;
		logic oe;
		paec_rx_t rx;
		logic done;
		logic ara;
	} paec_i2c_st_t;
	paec_i2c_st_t q, d;
	logic rise, fall, start, stop;
	logic [7:0] sh_n;

	// CRC-8 over one byte, polynomial x8+x2+x+1
	function automatic logic [7:0] paec_crc8(input logic [7:0] c, input logic [7:0] b);
		logic [7:0] r;
		r = c ^ b;
		for (int i = 0; i < 8; i++) r = r[7] ? ((r << 1) ^ PAEC_CRC_POLY) : (r << 1);
		return r;
	endfunction

	// Bit engine; pins are sampled at 200 MHz so both bus speeds fit
	always_comb begin
		d = q;
		d.rx.vld = 1'b0;
		d.done = 1'b0;
		d.ara = 1'b0;
		d.scl_s = {q.scl_s[1:0], scl_i};
		d.sda_s = {q.sda_s[1:0], sda_i};
		d.scl_f = paec_filt(q.scl_s, q.scl_f);
		d.sda_f = paec_filt(q.sda_s, q.sda_f);
		rise = d.scl_f && !q.scl_f;
		fall = !d.scl_f && q.scl_f;
		start = q.scl_f && d.scl_f && q.sda_f && !d.sda_f;
		stop = q.scl_f && d.scl_f && !q.sda_f && d.sda_f;
		sh_n = {q.sh[6:0], d.sda_f};
		unique case (q.st)
			I_IDLE: ;
			I_ADDR, I_RX: if (rise) begin
				d.sh = sh_n;
				d.bitc = q.bitc + 3'h1;
				if (q.bitc == 3'h7) begin
					d.crc = paec_crc8(q.crc, sh_n);
					d.st = I_ACK;
					d.ph = 1'b0;
					if (q.st == I_ADDR) begin
						d.rd = sh_n[0];
						d.mine = !sh_n[0] && sh_n[7:1] == own_addr;
						d.ack = d.mine || (sh_n[0] && sh_n[7:1] == PAEC_ADDR_ARA && alert);
						d.sh = {own_addr, 1'b0};
					end else begin
						d.ack = 1'b1;
						d.rx.vld = 1'b1;
						d.rx.idx = q.cnt;
						d.rx.data = sh_n;
						d.cnt = (q.cnt == 3'h7) ? q.cnt : q.cnt + 3'h1;
					end
				end
			end
			I_ACK: if (fall) begin
				d.ph = 1'b1;
				if (!q.ph) begin
					d.oe = q.ack;
					if (!q.ack) d.st = I_IDLE;
				end else if (q.rd) begin
					d.st = I_TX;
					d.oe = !q.sh[7];
				end else begin
					d.st = I_RX;
					d.oe = 1'b0;
				end
			end
			I_TX: begin
				if (rise) begin
					d.bitc = q.bitc + 3'h1;
					if (q.bitc == 3'h7) d.st = I_TXA;
				end
				if (fall) begin
					d.sh = q.sh << 1;
					d.oe = !q.sh[6];
				end
			end
			I_TXA: begin
				if (fall) d.oe = 1'b0;
				if (rise) begin
					d.ara = 1'b1;
					d.st = I_IDLE;
				end
			end
			default: d.st = I_IDLE;
		endcase
		// Start or repeated start restarts framing; stop closes it
		if (start) begin
			d.st = I_ADDR;
			d.bitc = '0;
			d.cnt = '0;
			d.crc = '0;
			d.oe = 1'b0;
			d.mine = 1'b0;
		end else if (stop) begin
			d.done = q.mine;
			d.st = I_IDLE;
			d.oe = 1'b0;
			d.mine = 1'b0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
			q.scl_s <= '1;
			q.sda_s <= '1;
			q.scl_f <= 1'b1;
			q.sda_f <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// Only the data pin is ever driven; the clock line is never held
	assign sda_o = 1'b0;
	assign sda_oe = q.oe;
	assign rx = q.rx;
	assign done = q.done;
	assign nbytes = q.cnt;
	assign crc_ok = (q.crc == '0);
	assign ara_done = q.ara;
endmodule

//--- core/paec_ctrl.sv
// PMBus alert, fault response, soft start and enable control with AHB-Lite
`timescale 1ns/1ps
module paec_ctrl #(
	parameter int TON_RISE_US = 1 // Output rise time in microseconds
) (
	input wire logic hclk, // System clock, 200 MHz
	input wire logic hresetn, // Async reset, active low
	input wire logic hsel, // AHB slave select
	input wire logic [31:0] haddr, // AHB address
	input wire logic [1:0] htrans, // AHB transfer type
	input wire logic hwrite, // AHB write
	input wire logic [2:0] hsize, // AHB size, words only
	input wire logic [31:0] hwdata, // AHB write data
	input wire logic hready, // AHB bus ready
	output logic hreadyout, // AHB slave ready
	output logic [31:0] hrdata, // AHB read data
	output logic hresp, // AHB response, always OKAY
	output logic irq, // Level interrupt
	input wire logic scl_i, // Bus clock pin
	input wire logic sda_i, // Bus data pin in
	output logic sda_o, // Bus data pin out
	output logic sda_oe, // Bus data pull-low enable
	output logic alert_o, // Alert pin out
	output logic alert_oe, // Alert pull-low enable
	input wire logic enable_control_pin, // External enable pin
	input wire logic vout_uv_warn, // Output undervoltage comparator
	input wire logic vout_ok, // Output within regulation window
	output paec_pkg::paec_gate_t gate, // Power switch drives
	output logic power_good_output, // Power good
	output logic nvm_store // One-cycle store request
);
	import paec_pkg::*;

	// ********************************
	// Types and constants
	// ********************************
	localparam int RISE_CYC = TON_RISE_US * PAEC_CLK_MHZ;
	localparam int WAIT_CYC = PAEC_RESTART_RISES * RISE_CYC;
	localparam int TMR_W = $clog2(WAIT_CYC + 1);
	localparam logic [TMR_W-1:0] RISE_LAST = TMR_W'(RISE_CYC - 1);
	localparam logic [TMR_W-1:0] WAIT_LAST = TMR_W'(WAIT_CYC - 1);
	typedef enum logic [2:0] {S_OFF, S_RISE, S_ON, S_LATCH, S_WAIT} paec_fsm_t;
	typedef struct packed {
		logic [2:0] en_s;
		logic [2:0] uv_s;
		logic [2:0] ok_s;
		logic en_f;
		logic uv_f;
		logic ok_f;
		logic wr_pend;
		logic [7:0] wr_off;
		logic [31:0] rdata;
		logic [15:0] opt;
		logic [PAEC_EV_N-1:0] int_en;
		logic [PAEC_EV_N-1:0] int_st;
		logic [PAEC_PM_N-1:0] pm_st;
		logic [PAEC_PM_N-1:0] mask;
		logic alert;
		logic op_on;
		logic [7:0] cmd;
		logic [7:0] dat;
		paec_fsm_t fsm;
		logic [TMR_W-1:0] tmr;
		logic [7:0] pwm;
		logic [7:0] ss;
		paec_gate_t gate;
		logic pg;
		logic store;
	} paec_st_t;

	paec_st_t q, d;
	paec_rx_t rx;
	logic done, crc_ok, ara_done, sel, pin_act, reg_en;
	logic exec, clear_f, run, hs, ls;
	logic [2:0] nbytes, len;
	logic [6:0] own_addr;
	logic [7:0] ramp;
	logic [PAEC_EV_N-1:0] ev, clr;
	logic [PAEC_PM_N-1:0] unm, nw;

	// ********************************
	// Bus slave link
	// ********************************
	// Loop role picks one of the two fixed addresses
	assign own_addr = q.opt[PAEC_OPT_LSLV] ? PAEC_ADDR_SLV : PAEC_ADDR_MST;

	paec_i2c u_link (
		.hclk(hclk),
		.hresetn(hresetn),
		.scl_i(scl_i),
		.sda_i(sda_i),
		.sda_o(sda_o),
		.sda_oe(sda_oe),
		.own_addr(own_addr),
		.alert(q.alert),
		.rx(rx),
		.done(done),
		.nbytes(nbytes),
		.crc_ok(crc_ok),
		.ara_done(ara_done)
	);

	// ********************************
	// Next state
	// ********************************
	always_comb begin
		d = q;
		ev = '0;
		clr = '0;
		// Pins come from outside the clock domain
		d.en_s = {q.en_s[1:0], enable_control_pin};
		d.uv_s = {q.uv_s[1:0], vout_uv_warn};
		d.ok_s = {q.ok_s[1:0], vout_ok};
		d.en_f = paec_filt(q.en_s, q.en_f);
		d.uv_f = paec_filt(q.uv_s, q.uv_f);
		d.ok_f = paec_filt(q.ok_s, q.ok_f);

		// AHB address phase; read data is caught here so it stands from a flop
		sel = hsel && hready && htrans[1];
		d.wr_pend = sel && hwrite;
		if (sel) d.wr_off = haddr[7:0];
		if (sel && !hwrite) begin
			case (haddr[7:0])
				PAEC_OFF_OPT: d.rdata = 32'(q.opt);
				PAEC_OFF_INT_ST: d.rdata = 32'(q.int_st);
				PAEC_OFF_INT_EN: d.rdata = 32'(q.int_en);
				PAEC_OFF_STATE: d.rdata = 32'({q.fsm == S_ON, q.pg, q.op_on,
					q.alert, q.mask, q.pm_st});
				default: d.rdata = '0;
			endcase
		end
		// AHB data phase write
		if (q.wr_pend) begin
			case (q.wr_off)
				PAEC_OFF_OPT: d.opt = hwdata[15:0];
				PAEC_OFF_INT_EN: d.int_en = hwdata[PAEC_EV_N-1:0];
				PAEC_OFF_INT_CLR: clr = hwdata[PAEC_EV_N-1:0];
				default: ;
			endcase
		end

		// Collect command and first data byte of a write
		if (rx.vld) begin
			if (rx.idx == '0) d.cmd = rx.data;
			else if (rx.idx == PAEC_LEN_1) d.dat = rx.data;
		end
		case (q.cmd)
			PAEC_CMD_CLR, PAEC_CMD_STORE: len = PAEC_LEN_1;
			PAEC_CMD_OPER, PAEC_CMD_MASK: len = PAEC_LEN_2;
			default: len = '0;
		endcase
		// One extra byte means a check byte; a short frame has none
		exec = 1'b0;
		if (done && len != '0) begin
			if (nbytes == len) begin
				exec = 1'b1;
			end else if (nbytes == len + PAEC_LEN_1) begin
				exec = crc_ok;
				ev[PAEC_EV_PEC] = !crc_ok;
			end
		end
		clear_f = exec && q.cmd == PAEC_CMD_CLR;
		if (exec && q.cmd == PAEC_CMD_OPER) d.op_on = q.dat[PAEC_OPER_ON];
		if (exec && q.cmd == PAEC_CMD_MASK) d.mask = q.dat[PAEC_PM_N-1:0];
		// Nothing is written back to memory unless the host asks
		d.store = exec && q.cmd == PAEC_CMD_STORE;
		ev[PAEC_EV_STORE] = d.store;
		ev[PAEC_EV_CLR] = clear_f;
		ev[PAEC_EV_ARA] = ara_done;

		// Enable source selection
		pin_act = q.en_f ^ q.opt[PAEC_OPT_POL];
		case (paec_en_mode_t'(q.opt[PAEC_OPT_MODE +: 2]))
			PAEC_EN_PIN: reg_en = pin_act;
			PAEC_EN_CMD: reg_en = q.op_on;
			default: reg_en = pin_act && q.op_on;
		endcase

		// Regulation sequence
		d.tmr = q.tmr + TMR_W'(1);
		unique case (q.fsm)
			S_OFF: begin
				d.tmr = '0;
				d.ss = '0;
				if (reg_en) d.fsm = S_RISE;
			end
			S_RISE: if (q.tmr == RISE_LAST) begin
				d.tmr = '0;
				if (q.ok_f) begin
					d.fsm = S_ON;
				end else begin
					ev[PAEC_EV_TON] = 1'b1;
					case (paec_resp_t'(q.opt[PAEC_OPT_RESP +: 2]))
						PAEC_RESP_LATCH: d.fsm = S_LATCH;
						PAEC_RESP_RESTART: d.fsm = S_WAIT;
						default: d.fsm = S_ON;
					endcase
				end
			end
			S_WAIT: if (q.tmr == WAIT_LAST) begin
				d.tmr = '0;
				d.ss = '0;
				d.fsm = S_RISE;
			end
			S_ON, S_LATCH: d.tmr = '0;
			default: d.fsm = S_OFF;
		endcase
		// Dropping the enable always wins and also clears a latch-off
		if (!reg_en) d.fsm = S_OFF;

		// Warning only counts once the rise is over; PWM is left running
		ev[PAEC_EV_UV] = q.uv_f && q.fsm == S_ON;

		// Fault status: set wins over a clear, so persistent faults come back
		d.pm_st = (clear_f ? '0 : q.pm_st) | {ev[PAEC_EV_PEC], ev[PAEC_EV_TON], ev[PAEC_EV_UV]};
		unm = d.pm_st & ~d.mask;
		nw = unm & ~(q.pm_st & ~q.mask);
		if (q.opt[PAEC_OPT_AUTO]) begin
			d.alert = (q.alert && !ara_done && |unm) || |nw;
		end else begin
			d.alert = |unm;
		end

		// Interrupt status, sticky, set wins over write-one-to-clear
		d.int_st = (q.int_st & ~clr) | ev;

		// Switching: 256-clock period; low side grows in over 128 periods
		run = q.fsm == S_RISE || q.fsm == S_ON;
		d.pwm = run ? q.pwm + 8'h1 : '0;
		if (run && q.pwm == '1 && q.ss != PAEC_SS_CYCLES) d.ss = q.ss + 8'h1;
		ramp = {q.ss[6:0], 1'b0};
		hs = run && q.pwm < q.opt[PAEC_OPT_DUTY +: 8];
		ls = run && !hs && (q.ss == PAEC_SS_CYCLES || ~q.pwm < ramp);
		d.gate.hs = hs;
		d.gate.ls = ls;
		// Power good drops on warning or on a timed-out rise
		d.pg = q.fsm == S_ON && q.ok_f && !q.uv_f && !q.pm_st[PAEC_EV_TON];
	end

	// ********************************
	// State register
	// ********************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
			q.opt <= PAEC_OPT_RST;
		end else begin
			q <= d;
		end
	end

	// Zero-wait slave; every transfer answers OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = q.rdata;
	assign irq = |(q.int_st & q.int_en);
	// Open-drain alert: only ever pulled low
	assign alert_o = 1'b0;
	assign alert_oe = q.alert;
	assign gate = q.gate;
	assign power_good_output = q.pg;
	assign nvm_store = q.store;

	// ********************************
	// Checks
	// ********************************
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	a_uv_rise_quiet: assert property (
		q.fsm == S_RISE && !q.pm_st[PAEC_EV_UV] |=> !q.pm_st[PAEC_EV_UV])
		else $error("uv warning flagged during rise");
	a_pg_uv_low: assert property (
		q.uv_f |=> !q.pg)
		else $error("power good high during uv warning");
	a_latch_off: assert property (
		q.fsm == S_LATCH |=> !q.gate.hs && !q.gate.ls)
		else $error("switches on in latch-off");
	a_restart_go: assert property (
		q.fsm == S_WAIT && q.tmr == WAIT_LAST && reg_en |=> q.fsm == S_RISE)
		else $error("restart not taken after wait");
	a_pec_bad: assert property (
		done && len != '0 && nbytes == len + PAEC_LEN_1 && !crc_ok
		|=> q.int_st[PAEC_EV_PEC] && $stable(q.op_on))
		else $error("bad check byte not flagged");
	a_alert_cause: assert property (
		q.alert |-> |(q.pm_st & ~q.mask))
		else $error("alert without unmasked status");
	a_std_hold: assert property (
		!q.opt[PAEC_OPT_AUTO] ##1 |(q.pm_st & ~q.mask) |-> q.alert)
		else $error("standard mode alert released early");
	a_auto_free: assert property (
		ara_done && q.opt[PAEC_OPT_AUTO] ##1 $stable(q.pm_st) && $stable(q.mask)
		|-> !q.alert)
		else $error("auto mode kept alert after reply");
	a_ss_full: assert property (
		q.fsm == S_ON && q.ss == PAEC_SS_CYCLES |=> q.gate.hs ^ q.gate.ls)
		else $error("switches not complementary after ramp");
	a_en_off: assert property (
		!reg_en |=> q.fsm == S_OFF)
		else $error("regulating while disabled");
	a_cmd_mode: assert property (
		q.opt[PAEC_OPT_MODE +: 2] == PAEC_EN_CMD && q.op_on && q.fsm == S_OFF
		|=> q.fsm == S_RISE)
		else $error("command mode did not start");
	a_store_once: assert property (
		q.store |=> !q.store)
		else $error("store request longer than one cycle");
	// Enable modes, the ignore response and the start of the low-side ramp
	a_pin_start: assert property (
		q.opt[PAEC_OPT_MODE +: 2] == PAEC_EN_PIN && pin_act && q.fsm == S_OFF
		|=> q.fsm == S_RISE)
		else $error("pin mode did not start");
	a_both_need: assert property (
		q.opt[PAEC_OPT_MODE +: 2] == PAEC_EN_BOTH && !(pin_act && q.op_on)
		|=> q.fsm == S_OFF)
		else $error("combined mode ran without both inputs");
	a_ls_ramp_start: assert property (
		q.ss == '0 |=> !q.gate.ls)
		else $error("low side on before the ramp began");
	a_ton_ignore: assert property (
		q.fsm == S_RISE && q.tmr == RISE_LAST && !q.ok_f && reg_en
		&& q.opt[PAEC_OPT_RESP +: 2] == PAEC_RESP_IGNORE |=> q.fsm == S_ON)
		else $error("ignore response stopped regulation");
endmodule

//--- test/paec_host.sv
// SMBus host model: bit-banged frames at a 160 ns bus clock
`timescale 1ns/1ps
module paec_host
	import paec_pkg::*;
(
	output logic scl, // Bus clock, only ever driven here
	output logic sda_h, // Our data drive, 1 = released
	input wire logic sda // Wired data level
);
	// Idle: clock stands high between frames, data released
	initial begin
		scl = 1'b1;
		sda_h = 1'b1;
	end
	// One bit: data moves while clock is low, sampled mid high phase
	// Pin moves land on system clock edges, so they are non-blocking to avoid a race
	task automatic bt(input logic b, output logic r);
		sda_h <= b;
		#40;
		scl <= 1'b1;
		#40;
		r = sda;
		#40;
		scl <= 1'b0;
		#40;
	endtask
	// Start, then clock parked low
	task automatic go();
		sda_h <= 1'b1;
		scl <= 1'b1;
		#80;
		sda_h <= 1'b0;
		#80;
		scl <= 1'b0;
		#40;
	endtask
	// Stop: data rises while clock is high
	task automatic halt();
		sda_h <= 1'b0;
		#40;
		scl <= 1'b1;
		#80;
		sda_h <= 1'b1;
		#80;
	endtask
	// Eight bits MSB first, then a ninth bit; mack 1 releases it
	task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
		output logic ack);
		logic a;
		for (int i = 7; i >= 0; i--) begin
			bt(d[i], q[i]);
		end
		bt(mack, a);
		ack = !a;
	endtask
	// Write frame of n bytes; stopping early means no check byte
	task automatic send(input logic [31:0] b, input int n, output logic ok);
		logic [7:0] q;
		logic a;
		ok = 1'b1;
		go();
		for (int i = 0; i < n; i++) begin
			xfer(b[31-8*i-:8], 1'b1, q, a);
			ok &= a;
		end
		halt();
	endtask
	// Alert reply read: the one byte back is NACKed to end it
	task automatic ara(output logic ok, output logic [7:0] q);
		logic [7:0] x;
		logic a;
		go();
		xfer({PAEC_ADDR_ARA, 1'b1}, 1'b1, x, ok);
		xfer(8'hff, 1'b1, q, a);
		halt();
	endtask
endmodule

//--- test/paec_ctrl_tb.sv
// Self-checking testbench for the PMBus alert and enable control block
`timescale 1ns/1ps
module paec_ctrl_tb;
	import paec_pkg::*;
	// ********
	// Signals
	// ********
	localparam logic [31:0] ALL = 32'hffffffff;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic pin = 1'b0;
	logic uv = 1'b0;
	logic vok = 1'b1;
	logic hreadyout, hresp, irq, sda_o, sda_oe, alert_o, alert_oe, pg, nvm_store;
	logic scl, sda_h, ok;
	logic [31:0] hrdata, r;
	logic [7:0] q;
	paec_gate_t gate;
	wire sda = sda_h & ~sda_oe; // Pull-up: either side may pull low
	int err_total = 0;
	int total_checks = 0;
	int stores = 0;

	always #2.5 hclk = ~hclk;
	// Store pulses are one cycle wide, so each high cycle is one store
	always @(posedge hclk) if (nvm_store === 1'b1) stores++;

	paec_ctrl #(.TON_RISE_US(1)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
		.hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
		.irq(irq), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
		.alert_o(alert_o), .alert_oe(alert_oe), .enable_control_pin(pin),
		.vout_uv_warn(uv), .vout_ok(vok), .gate(gate), .power_good_output(pg),
		.nvm_store(nvm_store));
	paec_host host (.scl(scl), .sda_h(sda_h), .sda(sda));

	// ********
	// Tasks
	// ********
	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	// Single word transfer; waits on ready in both phases
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		r = hrdata;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] k, input logic [31:0] e,
		input string m);
		ahb(1'b0, a, 32'h0);
		chk(r & k, e, m);
	endtask
	// Regulating flag after a wait
	task automatic st(input logic e, input int w, input string m);
		cyc(w);
		rdc(PAEC_OFF_STATE, 32'h200, {22'h0, e, 9'h0}, m);
	endtask
	task automatic pm(input logic [31:0] b, input int n, input logic e, input string m);
		host.send(b, n, ok);
		chk(ok, e, m);
		cyc(20);
	endtask
	function automatic logic [31:0] fr(input logic [6:0] a, input logic [7:0] c,
		input logic [15:0] d);
		return {a, 1'b0, c, d};
	endfunction
	// Check byte: CRC-8 with polynomial 07 over the first n bytes
	function automatic logic [7:0] crc(input logic [31:0] b, input int n);
		logic [7:0] c;
		c = 8'h00;
		for (int i = 0; i < n; i++) begin
			c ^= b[31-8*i-:8];
			repeat (8) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
		end
		return c;
	endfunction

	// ********
	// Scenarios
	// ********
	task automatic t_reset();
		rdc(PAEC_OFF_OPT, ALL, 32'h8008, "option reset");
		rdc(8'h20, ALL, 32'h0, "unmapped read");
		ahb(1'b1, PAEC_OFF_INT_ST, 32'hff);
		rdc(PAEC_OFF_INT_ST, ALL, 32'h0, "status is read-only");
		chk(hresp, 1'b0, "response");
		chk({hreadyout, sda_o, alert_o}, 32'h4, "fixed outputs");
		$display("done t_reset");
	endtask
	task automatic t_enable();
		pin <= 1'b1;
		st(1'b1, 300, "pin mode on");
		ahb(1'b1, PAEC_OFF_OPT, 32'h800c);
		st(1'b0, 30, "pin inverted");
		ahb(1'b1, PAEC_OFF_OPT, 32'h8009);
		st(1'b0, 30, "command mode off");
		pm(fr(PAEC_ADDR_MST, PAEC_CMD_OPER, 16'h8000), 3, 1'b1, "oper on");
		st(1'b1, 300, "command mode on");
		pin <= 1'b0;
		st(1'b1, 30, "pin ignored");
		ahb(1'b1, PAEC_OFF_OPT, 32'h800a);
		st(1'b0, 30, "both, pin low");
		pin <= 1'b1;
		uv <= 1'b1;
		cyc(100);
		rdc(PAEC_OFF_INT_ST, 32'h1, 32'h0, "warning during rise");
		uv <= 1'b0;
		st(1'b1, 300, "both on");
		pm(fr(PAEC_ADDR_MST, PAEC_CMD_OPER, 16'h0000), 3, 1'b1, "oper off");
		st(1'b0, 30, "both, op off");
		pm(fr(PAEC_ADDR_MST, PAEC_CMD_OPER, 16'h8000), 3, 1'b1, "oper on");
		st(1'b1, 300, "both on again");
		$display("done t_enable");
	endtask
	task automatic t_uv();
		ahb(1'b1, PAEC_OFF_INT_EN, 32'h1);
		uv <= 1'b1;
		cyc(20);
		chk(pg, 1'b0, "power good low");
		chk(alert_oe, 1'b1, "alert pulled");
		chk(irq, 1'b1, "interrupt");
		st(1'b1, 0, "pwm kept");
		rdc(PAEC_OFF_INT_ST, 32'h1, 32'h1, "warning status");
		host.ara(ok, q);
		chk(ok, 1'b1, "alert reply ack");
		chk(q, {PAEC_ADDR_MST, 1'b0}, "alert reply address");
		cyc(5);
		chk(alert_oe, 1'b0, "auto release");
		ahb(1'b1, PAEC_OFF_INT_EN, 32'h0);
		cyc(3);
		chk(irq, 1'b0, "interrupt masked");
		uv <= 1'b0;
		pm(fr(PAEC_ADDR_MST, PAEC_CMD_CLR, 16'h0), 2, 1'b1, "clear");
		ahb(1'b1, PAEC_OFF_INT_CLR, 32'h3f);
		rdc(PAEC_OFF_INT_ST, ALL, 32'h0, "status cleared");
		host.ara(ok, q);
		chk(ok, 1'b0, "reply refused");
		$display("done t_uv");
	endtask
	task automatic t_std();
		ahb(1'b1, PAEC_OFF_OPT, 32'h8002);
		uv <= 1'b1;
		cyc(20);
		chk(alert_oe, 1'b1, "standard alert");
		host.ara(ok, q);
		chk(ok, 1'b1, "standard reply");
		pm(fr(PAEC_ADDR_MST, PAEC_CMD_CLR, 16'h0), 2, 1'b1, "clear");
		chk(alert_oe, 1'b1, "persistent alert");
		pm(fr(PAEC_ADDR_MST, PAEC_CMD_MASK, 16'h0100), 3, 1'b1, "mask");
		pm(fr(PAEC_ADDR_MST, PAEC_CMD_CLR, 16'h0), 2, 1'b1, "clear");
		chk(alert_oe, 1'b0, "masked release");
		rdc(PAEC_OFF_STATE, 32'h1, 32'h1, "masked status");
		uv <= 1'b0;
		pm(fr(PAEC_ADDR_MST, PAEC_CMD_MASK, 16'h0000), 3, 1'b1, "unmask");
		pm(fr(PAEC_ADDR_MST, PAEC_CMD_CLR, 16'h0), 2, 1'b1, "clear");
		$display("done t_std");
	endtask
	task automatic t_pec();
		logic [31:0] b;
		chk(stores, 0, "no store unasked");
		b = fr(PAEC_ADDR_MST, PAEC_CMD_STORE, 16'h0);
		pm(b, 2, 1'b1, "store plain");
		chk(stores, 1, "store done");
		b[15:8] = crc(b, 2);
		pm(b, 3, 1'b1, "store checked");
		chk(stores, 2, "good check byte");
		b[15:8] ^= 8'h01;
		pm(b, 3, 1'b1, "store corrupt");
		chk(stores, 2, "bad check byte");
		rdc(PAEC_OFF_INT_ST, 32'h4, 32'h4, "check byte flag");
		pm(fr(PAEC_ADDR_MST, PAEC_CMD_CLR, 16'h0), 2, 1'b1, "clear");
		ahb(1'b1, PAEC_OFF_INT_CLR, 32'h3f);
		$display("done t_pec");
	endtask
	task automatic t_addr();
		ahb(1'b1, PAEC_OFF_OPT, 32'h8042);
		pm(fr(PAEC_ADDR_SLV, PAEC_CMD_CLR, 16'h0), 2, 1'b1, "slave address");
		pm(fr(PAEC_ADDR_MST, PAEC_CMD_CLR, 16'h0), 2, 1'b0, "master refused");
		ahb(1'b1, PAEC_OFF_OPT, 32'h8002);
		pm(fr(PAEC_ADDR_SLV, PAEC_CMD_CLR, 16'h0), 2, 1'b0, "slave refused");
		pm(fr(PAEC_ADDR_MST, PAEC_CMD_CLR, 16'h0), 2, 1'b1, "master address");
		$display("done t_addr");
	endtask
	// Rise never reaches the window; each response setting in turn
	task automatic t_ton();
		int first;
		int lsn;
		logic good;
		vok <= 1'b0;
		for (int k = 0; k < 3; k++) begin
			pin <= 1'b0;
			ahb(1'b1, PAEC_OFF_OPT, 32'h8002 | (k << 4));
			cyc(20);
			ahb(1'b1, PAEC_OFF_INT_CLR, 32'h3f);
			pin <= 1'b1;
			cyc(260);
			rdc(PAEC_OFF_INT_ST, 32'h2, 32'h2, "rise timeout");
			first = -1;
			lsn = 0;
			for (int i = 0; i < 1900; i++) begin
				if (first < 0 && gate !== 2'b00) first = i;
				if (gate.ls === 1'b1) lsn++;
				@(posedge hclk);
			end
			good = (k == 0) ? first < 0 : (k == 1) ? first > 1200 && first < 1500 :
				first >= 0 && first < 300;
			chk(good, 1'b1, "timeout response");
			// Early periods give the low side only a sliver, far below half
			if (k == 2) chk(lsn < 200, 1'b1, "low side ramping");
		end
		$display("done t_ton");
	endtask
	task automatic t_ramp();
		int bad;
		bad = 0;
		cyc(33000);
		repeat (512) begin
			if (gate.hs === gate.ls) bad++;
			@(posedge hclk);
		end
		chk(bad, 0, "complementary after ramp");
		$display("done t_ramp");
	endtask

	// ********
	// Sequence
	// ********
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	initial begin
		cyc(10);
		hresetn <= 1'b1;
		cyc(12);
		t_reset();
		t_enable();
		t_uv();
		t_std();
		t_pec();
		t_addr();
		t_ton();
		t_ramp();
		tally_and_finish();
	end
	// Watchdog, well past the expected run length
	initial begin
		#450000;
		err_total++;
		$display("BAD t=%0t watchdog expired", $time);
		tally_and_finish();
	end
endmodule
